// ---- pkg/ieu_params.svh ----
/*
 * Constants of the interrupt enable and priority unit: register
 * addresses, field positions, reset values, source order and vectors.
 * Assumes it is included by bare name from pkg/ on the include path.
 */
// Summary of operation
// RULE1 - build parameter picks six-source standard or thirteen-source extended unit
// RULE2 - external inputs 0 and 1 active low, each edge or level selectable
// RULE3 - extended unit: power-fail input level-sensitive, active high
// RULE4 - extended: requests 2,4 rising-edge; requests 3,5 falling-edge
// RULE5 - extended: watchdog request from input, rising edge, no internal source
// RULE6 - excluded serial ports or timer 2 never interrupt; their bits unused
// RULE7 - second serial enable and priority bits exist only in extended unit
// RULE8 - enable top bit gates all sources except power-fail
// RULE9 - enable bit 6 gates second serial port transmit or receive requests
// RULE10 - enable bit 5 gates timer 2 overflow or external flag requests
// RULE11 - enable bit 4 gates first serial port transmit or receive requests
// RULE12 - enable bits 3..0 gate timer1, ext1, timer0, ext0
// RULE13 - priority register top bit reserved, reads as one
// RULE14 - priority bit 6 sets second serial port low or high level
// RULE15 - priority bits 5,4 set timer 2 and first serial levels
// RULE16 - priority bits 3..0 set timer1, ext1, timer0, ext0 levels
// RULE17 - single-bit set, clear and test on enable and priority registers
// RULE18 - extended enable and priority registers exist only in extended unit
// RULE19 - equal-level requests resolved by fixed natural order, power-fail first
// RULE20 - routine preempted only by strictly higher level; power-fail alone top
// RULE21 - external inputs sampled once per instruction cycle at end of C4
// RULE22 - reset clears all enable and priority bits
// RULE23 - core clears edge-triggered external flags in software after service
`ifndef IEU_PARAMS_SVH
`define IEU_PARAMS_SVH

// ============================================================
// register addresses
`define IEU_ADDR_IE 8'hA8
`define IEU_ADDR_IP 8'hB8
`define IEU_ADDR_EIE 8'hE8
`define IEU_ADDR_EIP 8'hF8

// ============================================================
// field positions
`define IEU_IE_GLOBAL_BIT 7
`define IEU_IE_SER1_BIT 6
`define IEU_IP_RSVD_BIT 7
`define IEU_EXT_WDOG_BIT 4
`define IEU_EXT_IMPL_MASK 8'h1F
`define IEU_EXT_RSVD_MASK 8'hE0

// ============================================================
// reset values
`define IEU_IE_RESET 8'h00
`define IEU_IP_RESET 8'h00
`define IEU_EXT_RESET 8'h00

// ============================================================
// natural order of sources, lowest index wins among equals
`define IEU_NUM_SRC 13
`define IEU_SRC_PFI 0
`define IEU_SRC_EXT0 1
`define IEU_SRC_TMR0 2
`define IEU_SRC_EXT1 3
`define IEU_SRC_TMR1 4
`define IEU_SRC_SER0 5
`define IEU_SRC_TMR2 6
`define IEU_SRC_SER1 7
`define IEU_SRC_EXT2 8
`define IEU_SRC_WDOG 12

// ============================================================
// vector addresses, by natural order
`define IEU_VEC_TABLE {8'h63, 8'h5B, 8'h53, 8'h4B, 8'h43, 8'h3B, \
  8'h2B, 8'h23, 8'h1B, 8'h13, 8'h0B, 8'h03, 8'h33}

// conditioned inputs: ext0, ext1, pfi, ext2..ext5, watchdog
`define IEU_NUM_COND 8
`define IEU_COND_ACTIVE_HIGH 8'hAC
`define IEU_COND_EDGE_FIXED 8'hF8

`endif

// ---- pkg/ieu_pkg.sv ----
/*
 * Types of the interrupt enable and priority unit.
 * Assumes ieu_params.svh is compiled alongside it.
 */
package ieu_pkg;

  // ============================================================
  // request levels, ordered so a plain compare gives precedence
  typedef enum logic [1:0] {
    IEU_LVL_NONE = 2'b00,
    IEU_LVL_LOW = 2'b01,
    IEU_LVL_HIGH = 2'b10,
    IEU_LVL_TOP = 2'b11
  } ieu_level_e;

  typedef logic [3:0] ieu_src_t;

endpackage : ieu_pkg

// ---- pkg/ieu_src_if.sv ----
/*
 * Carrier between the unit and one input conditioner.
 * Assumes both ends share clk and rst_n.
 */
`timescale 1ns/1ps
interface ieu_src_if;
  logic sample;
  logic raw;
  logic edge_mode;
  logic clr;
  logic flag;

  modport cond (input sample, input raw, input edge_mode, input clr,
                output flag);
  modport ctl (output sample, output raw, output edge_mode, output clr,
               input flag);
endinterface : ieu_src_if

// ---- design/ieu_req_cond.sv ----
/*
 * Input conditioner: samples one request pin once per instruction
 * cycle and turns it into a level or a sticky edge flag.
 * Assumes the sample strobe is a one-cycle pulse at the end of C4.
 */
`timescale 1ns/1ps
module ieu_req_cond #(
  parameter bit ACTIVE_HIGH = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  ieu_src_if.cond s
);

  logic lvl_q;
  logic lvl_d;
  logic flag_q;
  logic flag_d;
  logic active;
  logic edge_seen;

  // ============================================================
  // sampling and edge detection
  always_comb begin
    active = ACTIVE_HIGH ? s.raw : ~s.raw; // RULE2 RULE4
    lvl_d = s.sample ? active : lvl_q; // RULE21
    edge_seen = s.sample & active & ~lvl_q;
    // set beats clear so an edge in the clearing cycle survives
    if (edge_seen) begin
      flag_d = 1'b1;
    end else if (s.clr) begin
      flag_d = 1'b0;
    end else begin
      flag_d = flag_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      flag_q <= flag_d;
    end
  end

  assign s.flag = s.edge_mode ? flag_q : lvl_q; // RULE2 RULE3

endmodule : ieu_req_cond

// ---- design/ieu_top.sv ----
/*
 * Interrupt enable and priority unit: enable and priority registers on
 * the special-function bus, source masking, priority choice over low, high and power-fail top levels
 * and in-service level tracking.
 * Assumes the core drives one-cycle strobes synchronous to clk, raises
 * irq_ack when it vectors and irq_reti when a routine returns.
 */
`timescale 1ns/1ps
`include "ieu_params.svh"
module ieu_top #(
  parameter bit EXTD_INTR = 1'b1, // RULE1
  parameter int SERIAL = 2,
  parameter bit TIMER2 = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_bit_set,
  input wire logic sfr_bit_clr,
  input wire logic [2:0] sfr_bit_idx,
  output logic sfr_hit,
  output logic [7:0] sfr_rdata,
  output logic sfr_bit_rdata,
  input wire logic cycle_c4,
  input wire logic ext_req0_low,
  input wire logic ext_req1_low,
  input wire logic ext0_edge_mode,
  input wire logic ext1_edge_mode,
  input wire logic pfi,
  input wire logic pfi_enable,
  input wire logic ext_req2_high,
  input wire logic ext_req3_low,
  input wire logic ext_req4_high,
  input wire logic ext_req5_low,
  input wire logic wdti,
  input wire logic [7:0] ext_flag_clr,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic timer2_overflow_flag,
  input wire logic timer2_external_flag,
  input wire logic serial0_tx_flag,
  input wire logic serial0_rx_flag,
  input wire logic serial1_tx_flag,
  input wire logic serial1_rx_flag,
  output logic [7:0] ext_flags,
  output logic irq_req,
  output logic [3:0] irq_src,
  output logic [7:0] irq_vector,
  input wire logic irq_ack,
  input wire logic irq_reti
);

  localparam logic [7:0] COND_AH = `IEU_COND_ACTIVE_HIGH;
  localparam logic [7:0] COND_EDGE = `IEU_COND_EDGE_FIXED;
  localparam logic [8*`IEU_NUM_SRC-1:0] VEC_TABLE = `IEU_VEC_TABLE;
  localparam bit SER0_ON = (SERIAL > 0);
  localparam bit SER1_ON = (SERIAL == 2) && EXTD_INTR;

  // ============================================================
  // register state
  logic [7:0] ie_q;
  logic [7:0] ie_d;
  logic [6:0] ip_q;
  logic [6:0] ip_d;
  logic [4:0] eie_q;
  logic [4:0] eie_d;
  logic [4:0] eip_q;
  logic [4:0] eip_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rbit_q;
  logic rbit_d;

  logic hit_ie;
  logic hit_ip;
  logic hit_eie;
  logic hit_eip;
  logic [7:0] rd_val;
  logic [7:0] ie_vis;
  logic [7:0] ip_vis;

  // ============================================================
  // address decode
  always_comb begin
    hit_ie = (sfr_addr == `IEU_ADDR_IE);
    hit_ip = (sfr_addr == `IEU_ADDR_IP);
    hit_eie = EXTD_INTR && (sfr_addr == `IEU_ADDR_EIE); // RULE18
    hit_eip = EXTD_INTR && (sfr_addr == `IEU_ADDR_EIP); // RULE18
    sfr_hit = hit_ie | hit_ip | hit_eie | hit_eip;
  end

  // ============================================================
  // read values; absent bits read as zero, reserved top bits as one
  always_comb begin
    ie_vis = ie_q;
    ip_vis = {1'b1, ip_q}; // RULE13
    if (!EXTD_INTR) begin
      ie_vis[`IEU_IE_SER1_BIT] = 1'b0; // RULE7
      ip_vis[`IEU_IE_SER1_BIT] = 1'b0; // RULE7
    end
    if (hit_ie) begin
      rd_val = ie_vis;
    end else if (hit_ip) begin
      rd_val = ip_vis;
    end else if (hit_eie) begin
      rd_val = `IEU_EXT_RSVD_MASK | {3'b000, eie_q};
    end else if (hit_eip) begin
      rd_val = `IEU_EXT_RSVD_MASK | {3'b000, eip_q};
    end else begin
      rd_val = 8'h00;
    end
  end

  // ============================================================
  // writes, byte wide or single bit
  function automatic logic [7:0] upd(input logic [7:0] cur,
                                     input logic hit);
    logic [7:0] nv;
    nv = cur;
    if (hit && sfr_wr) begin
      nv = sfr_wdata;
    end else if (hit && sfr_bit_set) begin
      nv[sfr_bit_idx] = 1'b1; // RULE17
    end else if (hit && sfr_bit_clr) begin
      nv[sfr_bit_idx] = 1'b0; // RULE17
    end
    return nv;
  endfunction : upd

  always_comb begin
    logic [7:0] tmp;
    tmp = 8'h00;
    ie_d = upd(ie_q, hit_ie);
    if (!EXTD_INTR) begin
      ie_d[`IEU_IE_SER1_BIT] = 1'b0; // RULE7
    end
    tmp = upd({1'b1, ip_q}, hit_ip);
    ip_d = tmp[6:0];
    if (!EXTD_INTR) begin
      ip_d[`IEU_IE_SER1_BIT] = 1'b0; // RULE7
    end
    tmp = upd({3'b000, eie_q}, hit_eie) & `IEU_EXT_IMPL_MASK;
    eie_d = tmp[4:0];
    tmp = upd({3'b000, eip_q}, hit_eip) & `IEU_EXT_IMPL_MASK;
    eip_d = tmp[4:0];
    rdata_d = sfr_rd ? rd_val : rdata_q;
    rbit_d = sfr_rd ? rd_val[sfr_bit_idx] : rbit_q; // RULE17
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ie_q <= `IEU_IE_RESET; // RULE22
      ip_q <= 7'(`IEU_IP_RESET); // RULE22
      eie_q <= 5'(`IEU_EXT_RESET); // RULE22
      eip_q <= 5'(`IEU_EXT_RESET); // RULE22
      rdata_q <= 8'h00;
      rbit_q <= 1'b0;
    end else begin
      ie_q <= ie_d;
      ip_q <= ip_d;
      eie_q <= eie_d;
      eip_q <= eip_d;
      rdata_q <= rdata_d;
      rbit_q <= rbit_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign sfr_bit_rdata = rbit_q;

  // ============================================================
  // input conditioning: ext0, ext1, pfi, ext2..ext5, watchdog
  ieu_src_if src [`IEU_NUM_COND] ();
  logic [7:0] cond_raw;
  logic [7:0] cond_edge;
  logic [7:0] cond_flag;

  assign cond_raw = {wdti, ext_req5_low, ext_req4_high, ext_req3_low,
                     ext_req2_high, pfi, ext_req1_low, ext_req0_low};
  assign cond_edge = COND_EDGE | {6'b000000, ext1_edge_mode,
                                  ext0_edge_mode}; // RULE2 RULE4 RULE5

  for (genvar g = 0; g < `IEU_NUM_COND; g++) begin : g_cond
    assign src[g].sample = cycle_c4; // RULE21
    assign src[g].raw = cond_raw[g];
    assign src[g].edge_mode = cond_edge[g];
    assign src[g].clr = ext_flag_clr[g]; // RULE23
    assign cond_flag[g] = src[g].flag;
    ieu_req_cond #(
      .ACTIVE_HIGH(COND_AH[g])
    ) u_cond (
      .clk(clk),
      .rst_n(rst_n),
      .s(src[g])
    );
  end

  assign ext_flags = cond_flag;

  // ============================================================
  // pending sources and their levels
  logic [`IEU_NUM_SRC-1:0] pend;
  logic [`IEU_NUM_SRC-1:0] hi;
  logic ga;

  always_comb begin
    ga = ie_q[`IEU_IE_GLOBAL_BIT]; // RULE8
    pend = '0;
    // power-fail ignores the global enable
    pend[`IEU_SRC_PFI] = EXTD_INTR & pfi_enable & cond_flag[2]; // RULE3 RULE8
    pend[`IEU_SRC_EXT0] = ga & ie_q[0] & cond_flag[0]; // RULE12
    pend[`IEU_SRC_TMR0] = ga & ie_q[1] & timer0_overflow_flag; // RULE12
    pend[`IEU_SRC_EXT1] = ga & ie_q[2] & cond_flag[1]; // RULE12
    pend[`IEU_SRC_TMR1] = ga & ie_q[3] & timer1_overflow_flag; // RULE12
    pend[`IEU_SRC_SER0] = SER0_ON & ga & ie_q[4]
                          & (serial0_tx_flag | serial0_rx_flag); // RULE6 RULE11
    pend[`IEU_SRC_TMR2] = TIMER2 & ga & ie_q[5]
                          & (timer2_overflow_flag
                             | timer2_external_flag); // RULE6 RULE10
    pend[`IEU_SRC_SER1] = SER1_ON & ga & ie_q[6]
                          & (serial1_tx_flag | serial1_rx_flag); // RULE6 RULE9
    for (int i = 0; i < 5; i++) begin
      pend[`IEU_SRC_EXT2 + i] = EXTD_INTR & ga & eie_q[i]
                                & cond_flag[3 + i]; // RULE4 RULE5
    end
    hi = '0;
    hi[7:1] = {ip_q[6], ip_q[5], ip_q[4], ip_q[3], ip_q[2], ip_q[1],
               ip_q[0]}; // RULE14 RULE15 RULE16
    hi[12:8] = eip_q;
  end

  // ============================================================
  // in-service levels and selection
  logic [2:0] isr_q;
  logic [2:0] isr_d;
  logic req_q;
  logic req_d;
  logic [3:0] sel_q;
  logic [3:0] sel_d;
  logic [1:0] sel_lvl_q;
  logic [1:0] sel_lvl_d;
  logic [1:0] cur_lvl;
  logic [7:0] vec_q;
  logic [7:0] vec_d;

  always_comb begin
    logic [1:0] lvl;
    logic found;
    lvl = ieu_pkg::IEU_LVL_NONE;
    found = 1'b0;
    if (isr_q[2]) begin
      cur_lvl = ieu_pkg::IEU_LVL_TOP;
    end else if (isr_q[1]) begin
      cur_lvl = ieu_pkg::IEU_LVL_HIGH;
    end else if (isr_q[0]) begin
      cur_lvl = ieu_pkg::IEU_LVL_LOW;
    end else begin
      cur_lvl = ieu_pkg::IEU_LVL_NONE;
    end
    sel_d = 4'h0;
    sel_lvl_d = ieu_pkg::IEU_LVL_NONE;
    // strictly greater keeps the earlier, natural-order winner
    for (int i = 0; i < `IEU_NUM_SRC; i++) begin
      if (i == `IEU_SRC_PFI) begin
        lvl = ieu_pkg::IEU_LVL_TOP; // RULE20
      end else if (hi[i]) begin
        lvl = ieu_pkg::IEU_LVL_HIGH;
      end else begin
        lvl = ieu_pkg::IEU_LVL_LOW;
      end
      if (pend[i] && (lvl > cur_lvl) && (!found || lvl > sel_lvl_d)) begin
        found = 1'b1; // RULE19 RULE20
        sel_d = 4'(i);
        sel_lvl_d = lvl;
      end
    end
    // withdraw the offer the cycle after the core takes it
    req_d = found & ~irq_ack;
    vec_d = VEC_TABLE[8*sel_d +: 8];
    isr_d = isr_q;
    if (irq_reti) begin
      if (isr_q[2]) begin
        isr_d[2] = 1'b0;
      end else if (isr_q[1]) begin
        isr_d[1] = 1'b0;
      end else begin
        isr_d[0] = 1'b0;
      end
    end
    if (irq_ack && req_q && sel_lvl_q != ieu_pkg::IEU_LVL_NONE) begin
      isr_d[sel_lvl_q - 2'd1] = 1'b1; // RULE20
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isr_q <= 3'b000;
      req_q <= 1'b0;
      sel_q <= 4'h0;
      sel_lvl_q <= ieu_pkg::IEU_LVL_NONE;
      vec_q <= 8'h00;
    end else begin
      isr_q <= isr_d;
      req_q <= req_d;
      sel_q <= sel_d;
      sel_lvl_q <= sel_lvl_d;
      vec_q <= vec_d;
    end
  end

  assign irq_req = req_q;
  assign irq_src = sel_q;
  assign irq_vector = vec_q;

endmodule : ieu_top

// ---- verif/ieu_properties.sv ----
/* Port assertions of the interrupt unit.
   Assumes it is bound to ieu_top with its parameters. */
`timescale 1ns/1ps
module ieu_properties #(
  parameter bit EXTD_INTR = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic [2:0] sfr_bit_idx,
  input wire logic sfr_hit,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_bit_rdata,
  input wire logic cycle_c4,
  input wire logic [7:0] ext_flags,
  input wire logic irq_req,
  input wire logic [3:0] irq_src,
  input wire logic [7:0] irq_vector,
  input wire logic irq_ack
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====
  // register bus
  a_hit_decode:
  assert property (sfr_hit == (sfr_addr inside {8'hA8, 8'hB8} ||
    (EXTD_INTR && sfr_addr inside {8'hE8, 8'hF8})))
    else $error("address decode wrong");
  a_miss_reads_zero:
  assert property (sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ip_top_one:
  assert property (sfr_rd && sfr_addr == 8'hB8 |=> sfr_rdata[7])
    else $error("priority top bit not one");
  a_ext_reserved:
  assert property (sfr_rd && sfr_hit && sfr_addr[7:5] == 3'b111
    |=> sfr_rdata[7:5] == 3'b111) else $error("extended top bits wrong");
  a_bit_read:
  assert property (sfr_rd |=> sfr_bit_rdata ==
    sfr_rdata[$past(sfr_bit_idx)]) else $error("bit test wrong");
  a_rdata_holds:
  assert property (!sfr_rd |=> $stable(sfr_rdata) && $stable(sfr_bit_rdata))
    else $error("read data moved");
  // ====
  // requests
  a_flag_at_c4:
  assert property ((ext_flags & ~$past(ext_flags)) != 8'h00
    |-> $past(cycle_c4)) else $error("flag set off sample");
  a_ack_drops_req:
  assert property (irq_ack |=> !irq_req) else $error("request kept");
  // pfi sits out of order, the rest step by 8 around it
  a_vector_match:
  assert property (irq_req |-> irq_vector == ((irq_src == 4'h0) ? 8'h33 :
    8'h03 + {1'b0, irq_src - 4'h1, 3'h0} +
    ((irq_src > 4'h6) ? 8'h08 : 8'h00))) else $error("vector wrong");
endmodule : ieu_properties

// ---- verif/ieu_core_model.sv ----
/* Core sequencer and timer/serial flag model.
   Assumes one clock with the unit; raise is a one-cycle set mask. */
`timescale 1ns/1ps
module ieu_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [12:0] raise,
  input wire logic irq_req,
  input wire logic [3:0] irq_src,
  output logic irq_ack,
  output logic irq_reti,
  output logic [7:0] ext_flag_clr,
  output logic [12:0] pend
);
  logic [4:0] cnt;
  // ====
  // take, service, return
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {irq_ack, irq_reti, ext_flag_clr, pend, cnt} <= '0;
    end else begin
      pend <= pend | raise;
      ext_flag_clr <= 8'h00;
      irq_ack <= 1'b0;
      irq_reti <= (cnt == 5'd3);
      if (cnt != 5'd0) begin
        cnt <= cnt - 5'd1;
      end
      if (irq_ack) begin
        cnt <= slow ? 5'd24 : 5'd8;
        pend[irq_src] <= 1'b0;
        ext_flag_clr <= (irq_src == 4'h1) ? 8'h01 :
          (irq_src == 4'h3) ? 8'h02 :
          (irq_src > 4'h7) ? 8'h08 << (irq_src - 4'h8) : 8'h00;
      end else if (irq_req && cnt == 5'd0) begin
        irq_ack <= 1'b1;
      end
    end
  end
endmodule : ieu_core_model

// ---- verif/ieu_top_bench.sv ----
/* Self-checking bench of the interrupt unit.
   Assumes design, pkg and core model are compiled first. */
`timescale 1ns/1ps
`define IEU_CHECK(act, exp) begin num_checks++; \
  if ((act) !== (exp)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, act, exp); end end
module ieu_top_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic bset = 1'b0;
  logic bclr = 1'b0;
  logic [2:0] bidx = 3'h0;
  logic c4 = 1'b0;
  logic [7:0] pins = 8'h53;
  logic [1:0] edge_md = 2'h3;
  logic pfi_en = 1'b0;
  logic slow = 1'b0;
  logic alt = 1'b0;
  logic [12:0] raise = 13'h0000;
  logic rd_seen = 1'b0;
  logic sfr_hit, sfr_bit_rdata, irq_req, irq_ack, irq_reti;
  logic [7:0] sfr_rdata, ext_flags, irq_vector, flag_clr;
  logic [3:0] irq_src, es;
  logic [12:0] pend;
  logic [17:0] er;
  logic [7:0] std_rdata;
  logic std_bit, std_req;
  logic [31:0] seed = 32'h0000_0035;
  logic [3:0] exp_src[$];
  logic [17:0] exp_rd[$];
  int failures = 0;
  int num_checks = 0;
  int ccnt = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    #1;
    ccnt++;
    c4 = (ccnt % 4 == 0);
  end

  ieu_top i_ieu_top (
    .clk(clk), .rst_n(rst_n), .sfr_addr(addr), .sfr_wdata(wdata),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_bit_set(bset), .sfr_bit_clr(bclr),
    .sfr_bit_idx(bidx), .sfr_hit(sfr_hit), .sfr_rdata(sfr_rdata),
    .sfr_bit_rdata(sfr_bit_rdata), .cycle_c4(c4),
    .ext_req0_low(pins[0]), .ext_req1_low(pins[1]),
    .ext0_edge_mode(edge_md[0]), .ext1_edge_mode(edge_md[1]),
    .pfi(pins[2]), .pfi_enable(pfi_en), .ext_req2_high(pins[3]),
    .ext_req3_low(pins[4]), .ext_req4_high(pins[5]),
    .ext_req5_low(pins[6]), .wdti(pins[7]), .ext_flag_clr(flag_clr),
    .timer0_overflow_flag(pend[2]), .timer1_overflow_flag(pend[4]),
    .timer2_overflow_flag(pend[6] & ~alt),
    .timer2_external_flag(pend[6] & alt),
    .serial0_tx_flag(pend[5] & ~alt), .serial0_rx_flag(pend[5] & alt),
    .serial1_tx_flag(pend[7] & ~alt), .serial1_rx_flag(pend[7] & alt),
    .ext_flags(ext_flags), .irq_req(irq_req), .irq_src(irq_src),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_reti(irq_reti));

  // standard build shares every input; it is never acknowledged
  ieu_top #(.EXTD_INTR(1'b0), .SERIAL(1), .TIMER2(1'b0)) i_ieu_top_std (
    .clk(clk), .rst_n(rst_n), .sfr_addr(addr), .sfr_wdata(wdata),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_bit_set(bset), .sfr_bit_clr(bclr),
    .sfr_bit_idx(bidx), .sfr_hit(), .sfr_rdata(std_rdata),
    .sfr_bit_rdata(std_bit), .cycle_c4(c4),
    .ext_req0_low(pins[0]), .ext_req1_low(pins[1]),
    .ext0_edge_mode(edge_md[0]), .ext1_edge_mode(edge_md[1]),
    .pfi(pins[2]), .pfi_enable(pfi_en), .ext_req2_high(pins[3]),
    .ext_req3_low(pins[4]), .ext_req4_high(pins[5]),
    .ext_req5_low(pins[6]), .wdti(pins[7]), .ext_flag_clr(flag_clr),
    .timer0_overflow_flag(pend[2]), .timer1_overflow_flag(pend[4]),
    .timer2_overflow_flag(pend[6] & ~alt),
    .timer2_external_flag(pend[6] & alt),
    .serial0_tx_flag(pend[5] & ~alt), .serial0_rx_flag(pend[5] & alt),
    .serial1_tx_flag(pend[7] & ~alt), .serial1_rx_flag(pend[7] & alt),
    .ext_flags(), .irq_req(std_req), .irq_src(), .irq_vector(),
    .irq_ack(1'b0), .irq_reti(1'b0));

  ieu_core_model i_ieu_core_model (.clk(clk), .rst_n(rst_n),
    .slow(slow), .raise(raise), .irq_req(irq_req), .irq_src(irq_src),
    .irq_ack(irq_ack), .irq_reti(irq_reti), .ext_flag_clr(flag_clr),
    .pend(pend));

  // ====
  // result watcher
  always @(posedge clk) begin
    rd_seen <= rd;
    if (rd_seen) begin
      er = exp_rd.pop_front();
      `IEU_CHECK({sfr_bit_rdata, sfr_rdata}, er[8:0])
      `IEU_CHECK({std_bit, std_rdata}, er[17:9])
    end
    if (irq_ack) begin
      es = (exp_src.size() != 0) ? exp_src.pop_front() : 4'hF;
      `IEU_CHECK(irq_src, es)
    end
  end

  // ====
  // drivers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr_t(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask : wr_t

  task automatic rd_t(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] se;
    // standard build: no second serial bits, no extended registers
    se = (a == 8'hE8 || a == 8'hF8) ? 8'h00 :
      (a == 8'hA8 || a == 8'hB8) ? (e & 8'hBF) : e;
    seed = xs(seed);
    addr = a;
    bidx = seed[2:0];
    rd = 1'b1;
    exp_rd.push_back({se[seed[2:0]], se, e[seed[2:0]], e});
    cyc(1);
    rd = 1'b0;
    cyc(1);
  endtask : rd_t

  task automatic bit_t(input logic [7:0] a, input logic [2:0] i,
                       input logic s);
    addr = a;
    bidx = i;
    bset = s;
    bclr = ~s;
    cyc(1);
    bset = 1'b0;
    bclr = 1'b0;
    cyc(1);
  endtask : bit_t

  // bounded wait; leftover expectations mean a lost or masked request
  task automatic drain();
    int n = 0;
    while (exp_src.size() != 0 && n < 400) begin
      cyc(1);
      n++;
    end
    `IEU_CHECK(exp_src.size() == 0, 1'b1)
    cyc(20);
  endtask : drain

  task automatic fire(input logic [12:0] m);
    slow = seed[3];
    alt = seed[4];
    seed = xs(seed);
    raise = m;
    cyc(1);
    raise = 13'h0000;
    drain();
  endtask : fire

  task automatic pulse(input logic [7:0] m, input int w);
    pins = pins ^ m;
    cyc(w);
    pins = pins ^ m;
    drain();
  endtask : pulse

  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  initial begin
    #(25 * 8000);
    failures++;
    finish_test();
  end

  // ====
  // main sequence
  initial begin
    int i;
    logic [7:0] v;
    logic [7:0] m;
    cyc(8);
    rst_n = 1'b1;
    rd_t(8'hA8, 8'h00);
    rd_t(8'hB8, 8'h80);
    rd_t(8'hE8, 8'hE0);
    rd_t(8'hF8, 8'hE0);
    for (i = 0; i < 4; i++) begin
      v = seed[15:8];
      wr_t(8'hA8, v);
      wr_t(8'hB8, v);
      wr_t(8'hE8, v);
      wr_t(8'hF8, v);
      wr_t(8'hD8, ~v);
      rd_t(8'hA8, v);
      rd_t(8'hB8, v | 8'h80);
      rd_t(8'hE8, v | 8'hE0);
      rd_t(8'hF8, v | 8'hE0);
      rd_t(8'hD8, 8'h00);
    end
    m = 8'h00;
    // the loop above leaves a random enable byte behind
    wr_t(8'hA8, 8'h00);
    wr_t(8'hB8, 8'hFF);
    for (i = 0; i < 8; i++) begin
      bit_t(8'hA8, 3'(i), 1'b1);
      bit_t(8'hB8, 3'(i), 1'b0);
      m[i] = 1'b1;
      rd_t(8'hA8, m);
      rd_t(8'hB8, ~m | 8'h80);
    end
    wr_t(8'hE8, 8'h00);
    wr_t(8'hF8, 8'h00);
    exp_src = {4'h2, 4'h4, 4'h5, 4'h6, 4'h7};
    fire(13'h00F4);
    for (i = 3; i < 7; i++) begin
      wr_t(8'hB8, 8'h01 << i);
      exp_src = {4'(i + 1), 4'h2};
      fire(13'h0004 | (13'h0002 << i));
    end
    wr_t(8'hB8, 8'h00);
    // timer 2 and second serial pending: excluded in the standard build
    wr_t(8'hA8, 8'hE0);
    exp_src = {4'h6, 4'h7};
    raise = 13'h00C0;
    cyc(1);
    raise = 13'h0000;
    cyc(2);
    `IEU_CHECK(std_req, 1'b0)
    drain();
    wr_t(8'hA8, 8'h7F);
    fire(13'h0004);
    pfi_en = 1'b1;
    exp_src = {4'h0};
    pulse(8'h04, 4);
    pfi_en = 1'b0;
    wr_t(8'hA8, 8'h80);
    cyc(20);
    exp_src = {4'h2};
    wr_t(8'hA8, 8'h82);
    drain();
    wr_t(8'hA8, 8'h85);
    wr_t(8'hE8, 8'h1F);
    exp_src = {4'h1, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
    pulse(8'hFB, 8);
    edge_md = 2'b01;
    exp_src = {4'h3};
    pulse(8'h02, 4);
    finish_test();
  end
endmodule : ieu_top_bench

bind ieu_top ieu_properties #(.EXTD_INTR(EXTD_INTR)) i_ieu_properties (
  .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
  .sfr_bit_idx(sfr_bit_idx), .sfr_hit(sfr_hit), .sfr_rdata(sfr_rdata),
  .sfr_bit_rdata(sfr_bit_rdata), .cycle_c4(cycle_c4),
  .ext_flags(ext_flags), .irq_req(irq_req), .irq_src(irq_src),
  .irq_vector(irq_vector), .irq_ack(irq_ack));
